// *** inc/eewp_pkg.sv ***
/*
 * Shared constants and types of the serial EEPROM slave core: memory shape,
 * slave address prefix, erased value, clock rate and internal write time.
 * Assumes it is compiled before every file that imports it.
 */
`default_nettype none

package eewp_pkg;

    localparam int EEWP_CLK_PERIOD_NS = 8;
    localparam int EEWP_WR_TIME_NS = 100000;
    localparam int EEWP_WR_CYCLES = EEWP_WR_TIME_NS / EEWP_CLK_PERIOD_NS;

    localparam int EEWP_ADDR_W = 10;
    localparam int EEWP_DATA_W = 8;
    localparam int EEWP_PAGE_W = 4;
    localparam int EEWP_MEM_DEPTH = 1 << EEWP_ADDR_W;
    localparam int EEWP_PAGE_BYTES = 1 << EEWP_PAGE_W;
    localparam int EEWP_BUF_DEPTH = 2;
    localparam int EEWP_SYNC_W = 4;

    localparam logic [3:0] EEWP_DEV_PREFIX = 4'hA;
    localparam logic [7:0] EEWP_ERASED = 8'hFF;
    localparam logic [3:0] EEWP_BITS_PER_BYTE = 4'h8;

    // Bit positions inside the synchronised pin vector.
    localparam int EEWP_PIN_SCL = 0;
    localparam int EEWP_PIN_SDA = 1;
    localparam int EEWP_PIN_WP = 2;
    localparam int EEWP_PIN_CS = 3;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_WADDR,
        ST_WADDR_ACK,
        ST_WDATA,
        ST_WDATA_ACK,
        ST_RDATA,
        ST_RACK,
        ST_IGNORE
    } eewp_state_t;

endpackage

`default_nettype wire

// *** inc/eewp_strm_if.sv ***
/*
 * Valid/ready word stream between the read prefetch logic, the two-entry
 * buffer and the serial transmitter.
 * Assumes both ends run on the same clock.
 */
`default_nettype none

interface eewp_strm_if #(
    parameter int W = 8
);
    logic [W-1:0] data;
    logic valid;
    logic ready;

    modport producer(output data, output valid, input ready);
    modport consumer(input data, input valid, output ready);
endinterface

`default_nettype wire

// *** hw/eewp_pin_sync.sv ***
/*
 * Two-flop synchroniser for the bus and strap pins, with one extra stage
 * that holds the previous synchronised level for edge detection.
 * Assumes the pins are asynchronous to clk_i.
 */
`default_nettype none

module eewp_pin_sync #(
    parameter int W = 4
) (
    // Clock, reset and enable.
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic clk_en_i,
    // Pins and synchronised levels.
    input wire logic [W-1:0] pins_i,
    output logic [W-1:0] lvl_o,
    output logic [W-1:0] lvl_d_o
);

    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;
    logic [W-1:0] prev_reg;

    // The first stage feeds nothing but the second stage.
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            meta_reg <= '1;
            sync_reg <= '1;
            prev_reg <= '1;
        end
        else if (clk_en_i)
        begin
            meta_reg <= pins_i;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    assign lvl_o = sync_reg;
    assign lvl_d_o = prev_reg;

endmodule

`default_nettype wire

// *** hw/eewp_buf.sv ***
/*
 * Small FIFO with valid and ready on both sides and a synchronous flush.
 * Assumes the drain side may hold ready low for any time.
 */
`default_nettype none

module eewp_buf #(
    parameter int W = 8,
    parameter int DEPTH = 2
) (
    // Clock, reset and enable.
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic clk_en_i,
    // Discards every stored word.
    input wire logic flush_i,
    // Fill and drain sides.
    eewp_strm_if.consumer in_s,
    eewp_strm_if.producer out_s
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [W-1:0] mem_reg [DEPTH];
    logic [PW-1:0] wr_reg;
    logic [PW-1:0] rd_reg;
    logic [CW-1:0] cnt_reg;
    logic push;
    logic pop;

    assign in_s.ready = (cnt_reg != CW'(DEPTH)) && !flush_i;
    assign out_s.valid = (cnt_reg != '0);
    assign out_s.data = mem_reg[rd_reg];
    assign push = in_s.valid && in_s.ready;
    assign pop = out_s.valid && out_s.ready && !flush_i;

    function automatic logic [PW-1:0] wrap_inc(input logic [PW-1:0] p);
        return (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
    endfunction

    always_ff @(posedge clk_i)
    begin
        if (clk_en_i && push)
            mem_reg[wr_reg] <= in_s.data;
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
        end
        else if (clk_en_i)
        begin
            if (flush_i)
            begin
                wr_reg <= '0;
                rd_reg <= '0;
                cnt_reg <= '0;
            end
            else
            begin
                if (push)
                    wr_reg <= wrap_inc(wr_reg);
                if (pop)
                    rd_reg <= wrap_inc(rd_reg);
                if (push && !pop)
                    cnt_reg <= CW'(cnt_reg + 1'b1);
                else if (pop && !push)
                    cnt_reg <= CW'(cnt_reg - 1'b1);
            end
        end
    end

endmodule

`default_nettype wire

// *** hw/eewp_top.sv ***
/*
 * Two-wire serial EEPROM slave: address match, byte address, page-buffered
 * writes with hardware write protection, and current, random and
 * sequential reads through a two-entry prefetch buffer.
 * Assumes an outside master makes SCL and all conditions; SDA is open drain.
 */
`default_nettype none

module eewp_top
    import eewp_pkg::*;
#(
    parameter int WR_CYCLES = eewp_pkg::EEWP_WR_CYCLES
) (
    // Clock, reset and enable.
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic clk_en_i,
    // Serial bus.
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    // Straps and status.
    input wire logic wp_i,
    input wire logic chip_select_address_pin_i,
    output logic write_busy_o
);
    import eewp_pkg::*;

    localparam int CW = $clog2(WR_CYCLES);

    logic [EEWP_SYNC_W-1:0] lvl;
    logic [EEWP_SYNC_W-1:0] lvl_d;
    logic scl_s, sda_s, wp_s, cs_s, rise, fall, start_c, stop_c;
    eewp_state_t state_reg;
    logic [7:0] rx_reg;
    logic [7:0] tx_reg;
    logic [3:0] cnt_reg;
    logic rw_reg, mack_reg, wp_latch_reg, oe_reg, busy_reg;
    logic [1:0] hi_reg;
    logic [EEWP_ADDR_W-1:0] ptr_reg;
    logic [EEWP_ADDR_W-1:0] fa_reg;
    logic [EEWP_DATA_W-1:0] mem_reg [EEWP_MEM_DEPTH];
    logic [EEWP_MEM_DEPTH-1:0] prog_reg;
    logic [EEWP_DATA_W-1:0] pbuf_reg [EEWP_PAGE_BYTES];
    logic [EEWP_PAGE_BYTES-1:0] mask_reg;
    logic [EEWP_ADDR_W-EEWP_PAGE_W-1:0] page_reg;
    logic [CW-1:0] cyc_reg;
    logic byte_done, addr_hit, rd_active, flush, fetch, pop, store, reject;
    logic wr_start, commit, wr_end;

    eewp_strm_if #(.W(EEWP_DATA_W)) pre_s();
    eewp_strm_if #(.W(EEWP_DATA_W)) tx_s();

    eewp_pin_sync #(.W(EEWP_SYNC_W)) u_sync (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .clk_en_i(clk_en_i),
        .pins_i({chip_select_address_pin_i, wp_i, sda_i, scl_i}),
        .lvl_o(lvl),
        .lvl_d_o(lvl_d)
    );

    eewp_buf #(.W(EEWP_DATA_W), .DEPTH(EEWP_BUF_DEPTH)) u_buf (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .clk_en_i(clk_en_i),
        .flush_i(flush),
        .in_s(pre_s),
        .out_s(tx_s)
    );

    // Low four bits advance, the page bits stay put.
    function automatic logic [EEWP_ADDR_W-1:0] page_inc(input logic [EEWP_ADDR_W-1:0] a);
        return {a[EEWP_ADDR_W-1:EEWP_PAGE_W], EEWP_PAGE_W'(a[EEWP_PAGE_W-1:0] + 1'b1)};
    endfunction

    assign scl_s = lvl[EEWP_PIN_SCL];
    assign sda_s = lvl[EEWP_PIN_SDA];
    assign wp_s = lvl[EEWP_PIN_WP];
    assign cs_s = lvl[EEWP_PIN_CS];
    assign rise = clk_en_i && scl_s && !lvl_d[EEWP_PIN_SCL];
    assign fall = clk_en_i && !scl_s && lvl_d[EEWP_PIN_SCL];
    assign start_c = clk_en_i && scl_s && lvl_d[EEWP_PIN_SCL] && lvl_d[EEWP_PIN_SDA] && !sda_s;
    assign stop_c = clk_en_i && scl_s && lvl_d[EEWP_PIN_SCL] && !lvl_d[EEWP_PIN_SDA] && sda_s;
    assign byte_done = fall && (cnt_reg == EEWP_BITS_PER_BYTE);
    assign addr_hit = (rx_reg[7:4] == EEWP_DEV_PREFIX) && (rx_reg[3] == cs_s);

    assign rd_active = rw_reg && (state_reg == ST_ADDR_ACK || state_reg == ST_RDATA ||
                                  state_reg == ST_RACK);
    assign flush = (state_reg == ST_ADDR) && byte_done && addr_hit && rx_reg[0];
    assign pre_s.valid = rd_active && !flush;
    assign pre_s.data = prog_reg[fa_reg] ? mem_reg[fa_reg] : EEWP_ERASED;
    assign fetch = clk_en_i && pre_s.valid && pre_s.ready;
    assign pop = fall && tx_s.valid &&
                 ((state_reg == ST_ADDR_ACK && rw_reg) ||
                  (state_reg == ST_RACK && mack_reg));
    assign tx_s.ready = pop;
    assign store = (state_reg == ST_WDATA) && byte_done && !wp_latch_reg;
    assign reject = (state_reg == ST_WDATA) && byte_done && wp_latch_reg;
    assign wr_start = stop_c && !busy_reg && (mask_reg != '0);
    assign commit = clk_en_i && busy_reg && (cyc_reg[CW-1:EEWP_PAGE_W] == '0);
    assign wr_end = clk_en_i && busy_reg && (cyc_reg == CW'(WR_CYCLES - 1));

    // Bus protocol engine.
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            state_reg <= ST_IDLE;
            rx_reg <= '0;
            tx_reg <= '0;
            cnt_reg <= '0;
            rw_reg <= 1'b0;
            mack_reg <= 1'b0;
            hi_reg <= '0;
            wp_latch_reg <= 1'b0;
            oe_reg <= 1'b0;
            ptr_reg <= '0;
        end
        else if (stop_c)
        begin
            state_reg <= ST_IDLE;
            oe_reg <= 1'b0;
        end
        else if (start_c)
        begin
            state_reg <= busy_reg ? ST_IGNORE : ST_ADDR;
            cnt_reg <= '0;
            oe_reg <= 1'b0;
        end
        else if (clk_en_i)
        begin
            unique case (state_reg)
                ST_IDLE, ST_IGNORE:
                    oe_reg <= 1'b0;
                ST_ADDR, ST_WADDR, ST_WDATA:
                begin
                    if (rise)
                    begin
                        rx_reg <= {rx_reg[6:0], sda_s};
                        cnt_reg <= 4'(cnt_reg + 1'b1);
                    end
                    if (byte_done)
                    begin
                        cnt_reg <= '0;
                        if (state_reg == ST_ADDR)
                        begin
                            rw_reg <= rx_reg[0];
                            hi_reg <= rx_reg[2:1];
                            state_reg <= addr_hit ? ST_ADDR_ACK : ST_IGNORE;
                            oe_reg <= addr_hit;
                        end
                        else if (state_reg == ST_WADDR)
                        begin
                            ptr_reg <= {hi_reg, rx_reg};
                            state_reg <= ST_WADDR_ACK;
                            oe_reg <= 1'b1;
                        end
                        else if (wp_latch_reg)
                        begin
                            state_reg <= ST_IGNORE;
                        end
                        else
                        begin
                            ptr_reg <= page_inc(ptr_reg);
                            state_reg <= ST_WDATA_ACK;
                            oe_reg <= 1'b1;
                        end
                    end
                end
                ST_ADDR_ACK:
                    if (fall)
                    begin
                        if (!rw_reg)
                        begin
                            state_reg <= ST_WADDR;
                            oe_reg <= 1'b0;
                        end
                        else if (pop)
                        begin
                            tx_reg <= tx_s.data;
                            oe_reg <= !tx_s.data[7];
                            cnt_reg <= 4'h1;
                            ptr_reg <= EEWP_ADDR_W'(ptr_reg + 1'b1);
                            state_reg <= ST_RDATA;
                        end
                        else
                        begin
                            oe_reg <= 1'b0;
                            state_reg <= ST_IGNORE;
                        end
                    end
                ST_WADDR_ACK, ST_WDATA_ACK:
                    if (fall)
                    begin
                        oe_reg <= 1'b0;
                        state_reg <= ST_WDATA;
                        if (state_reg == ST_WADDR_ACK)
                            wp_latch_reg <= wp_s;
                    end
                ST_RDATA:
                    if (fall)
                    begin
                        if (cnt_reg == EEWP_BITS_PER_BYTE)
                        begin
                            oe_reg <= 1'b0;
                            state_reg <= ST_RACK;
                        end
                        else
                        begin
                            oe_reg <= !tx_reg[6];
                            tx_reg <= {tx_reg[6:0], 1'b1};
                            cnt_reg <= 4'(cnt_reg + 1'b1);
                        end
                    end
                ST_RACK:
                begin
                    if (rise)
                        mack_reg <= !sda_s;
                    if (fall)
                    begin
                        mack_reg <= 1'b0;
                        if (pop)
                        begin
                            tx_reg <= tx_s.data;
                            oe_reg <= !tx_s.data[7];
                            cnt_reg <= 4'h1;
                            ptr_reg <= EEWP_ADDR_W'(ptr_reg + 1'b1);
                            state_reg <= ST_RDATA;
                        end
                        else
                        begin
                            state_reg <= ST_IGNORE;
                        end
                    end
                end
            endcase
        end
    end

    // Read prefetch address runs over the whole array and wraps.
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            fa_reg <= '0;
        else if (clk_en_i && flush)
            fa_reg <= ptr_reg;
        else if (fetch)
            fa_reg <= EEWP_ADDR_W'(fa_reg + 1'b1);
    end

    // Page buffer collects bytes until STOP; a refused write empties it.
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            mask_reg <= '0;
            page_reg <= '0;
        end
        else if (clk_en_i)
        begin
            if (wr_end || reject || (start_c && !busy_reg))
                mask_reg <= '0;
            else if (store)
            begin
                mask_reg[ptr_reg[EEWP_PAGE_W-1:0]] <= 1'b1;
                page_reg <= ptr_reg[EEWP_ADDR_W-1:EEWP_PAGE_W];
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (clk_en_i && store)
            pbuf_reg[ptr_reg[EEWP_PAGE_W-1:0]] <= rx_reg;
    end

    // Internal write cycle timer; the page is copied in its first cycles.
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            busy_reg <= 1'b0;
            cyc_reg <= '0;
        end
        else if (clk_en_i)
        begin
            if (wr_start)
            begin
                busy_reg <= 1'b1;
                cyc_reg <= '0;
            end
            else if (wr_end)
                busy_reg <= 1'b0;
            else if (busy_reg)
                cyc_reg <= CW'(cyc_reg + 1'b1);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (commit && mask_reg[cyc_reg[EEWP_PAGE_W-1:0]])
            mem_reg[{page_reg, cyc_reg[EEWP_PAGE_W-1:0]}] <= pbuf_reg[cyc_reg[EEWP_PAGE_W-1:0]];
    end

    // Cleared marks mean erased locations.
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            prog_reg <= '0;
        else if (commit && mask_reg[cyc_reg[EEWP_PAGE_W-1:0]])
            prog_reg[{page_reg, cyc_reg[EEWP_PAGE_W-1:0]}] <= 1'b1;
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            sda_o <= 1'b0;
            sda_oe_o <= 1'b0;
            write_busy_o <= 1'b0;
        end
        else if (clk_en_i)
        begin
            sda_oe_o <= oe_reg && !busy_reg;
            write_busy_o <= busy_reg;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    sequence s_read_addr;
        (state_reg == ST_ADDR) && byte_done && addr_hit && rx_reg[0];
    endsequence

    a_wp_refuse: assert property (reject |=> state_reg == ST_IGNORE ##1 !sda_oe_o)
        else $error("protected data byte was acknowledged");
    a_wp_noprog: assert property (reject |=> mask_reg == '0 && !busy_reg)
        else $error("protected write started a write cycle");
    a_wp_acks: assert property (store |=> oe_reg ##1 sda_oe_o)
        else $error("unprotected data byte not acknowledged");
    a_wp_sample: assert property ((state_reg == ST_WADDR_ACK) && fall |=>
                                  wp_latch_reg == $past(wp_s))
        else $error("write protect not sampled at ack clock fall");
    a_read_start: assert property (s_read_addr |=> flush == 1'b0 && fa_reg == $past(ptr_reg))
        else $error("read did not start at current pointer");
    a_erased_val: assert property (fetch && !prog_reg[fa_reg] |-> pre_s.data == 8'hFF)
        else $error("erased location did not read all ones");
    a_seq_next: assert property (pop |=> ptr_reg == $past(ptr_reg) + 10'h001)
        else $error("read pointer did not advance by one");
    a_page_wrap: assert property (store |=> ptr_reg[9:4] == $past(ptr_reg[9:4]) &&
                                  ptr_reg[3:0] == $past(ptr_reg[3:0]) + 4'h1)
        else $error("write pointer left its page");
    a_busy_quiet: assert property (busy_reg && start_c |=> state_reg == ST_IGNORE [*2])
        else $error("device answered during write cycle");
    a_dummy_write: assert property (stop_c && mask_reg == '0 |=> !busy_reg)
        else $error("dummy write started a write cycle");
    a_stop_idle: assert property (stop_c |=> state_reg == ST_IDLE && !oe_reg)
        else $error("stop did not return to standby");

endmodule

`default_nettype wire

// *** sim/eewp_master.sv ***
/*
 * Bus master model: START, STOP, byte write and byte read. Each acknowledge
 * or read byte is posted on a one-clock strobe.
 * Assumes sda_i is the wire level and one bit lasts 8 clocks.
 */
`default_nettype none

module eewp_master (
    // Clock.
    input wire logic clk_i,
    // Bus.
    output logic scl_o,
    output logic sda_o,
    input wire logic sda_i,
    // Results.
    output logic res_v_o,
    output logic [8:0] res_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        scl_o = 1'b1;
        sda_o = 1'b1;
        res_v_o = 1'b0;
        res_o = 9'h000;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic step(input int n, input logic c, input logic d);
        tick(n);
        scl_o <= c;
        sda_o <= d;
    endtask
    task automatic post(input logic [8:0] v);
        res_o <= v;
        res_v_o <= 1'b1;
        tick(1);
        res_v_o <= 1'b0;
    endtask
    // Data moves only while the clock is low; the level is taken late in the high phase.
    task automatic bit_io(input logic b, output logic r);
        step(2, 1'b0, b);
        step(3, 1'b1, b);
        tick(2);
        r = sda_i;
        step(1, 1'b0, b);
    endtask
    // Also serves as a repeated START after a byte.
    task automatic cond_start();
        step(2, 1'b0, 1'b1);
        step(4, 1'b1, 1'b1);
        step(4, 1'b1, 1'b0);
        step(4, 1'b0, 1'b0);
    endtask
    task automatic cond_stop();
        step(2, 1'b0, 1'b0);
        step(4, 1'b1, 1'b0);
        step(4, 1'b1, 1'b1);
        tick(4);
    endtask
    task automatic write_byte(input logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(b[i], r);
        bit_io(1'b1, r);
        post({8'h80, ~r});
    endtask
    task automatic read_byte(input logic ack);
        logic [7:0] v;
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, v[i]);
        bit_io(~ack, r);
        post({1'b0, v});
    endtask
endmodule

`default_nettype wire

// *** sim/eewp_top_tb.sv ***
/*
 * Self-checking bench of the EEPROM slave: reads, page and memory wrap,
 * busy polling, write protection and address mismatch.
 * Assumes the master model posts one result per acknowledge or read byte.
 */
`default_nettype none

module eewp_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import eewp_pkg::*;
    localparam int WR_CYC = 256;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic wp = 1'b0;
    logic cs_pin = 1'b0;
    logic scl;
    logic sda_m;
    logic sda_d;
    logic sda_oe;
    logic sda_w;
    logic busy;
    logic res_v;
    logic [8:0] res;
    logic [8:0] exp_v;
    logic [8:0] exp_q[$];
    logic [7:0] d0;
    logic [7:0] d1;
    int err_count = 0;
    int comparisons = 0;
    integer seed = 32'h1b4e;
    // Open-drain wire with a pull-up.
    assign sda_w = sda_m & ~(sda_oe & ~sda_d);
    initial
    begin
        forever #4 clk = ~clk;
    end
    eewp_top #(.WR_CYCLES(WR_CYC)) u_dut (
        .clk_i(clk), .reset_n_i(reset_n), .clk_en_i(1'b1), .scl_i(scl), .sda_i(sda_w),
        .sda_o(sda_d), .sda_oe_o(sda_oe), .wp_i(wp), .chip_select_address_pin_i(cs_pin),
        .write_busy_o(busy));
    eewp_master u_mst (
        .clk_i(clk), .scl_o(scl), .sda_o(sda_m), .sda_i(sda_w), .res_v_o(res_v), .res_o(res));
    task automatic fail(input string what, input logic [8:0] e, input logic [8:0] s);
        err_count++;
        $display("wrong value %s: expected %h, seen %h", what, e, s);
    endtask
    task automatic complete_run();
        if (exp_q.size() != 0)
            fail("pending results", 9'h000, 9'(exp_q.size()));
        $display("comparisons %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge clk)
    begin
        if (res_v === 1'b1)
        begin
            exp_v = (exp_q.size() != 0) ? exp_q.pop_front() : 9'h1FF;
            comparisons++;
            if (res !== exp_v)
                fail("bus result", exp_v, res);
        end
    end
    function automatic logic [7:0] dev(input logic [1:0] hi, input logic rd);
        return {EEWP_DEV_PREFIX, cs_pin, hi, rd};
    endfunction
    task automatic wr(input logic [7:0] b, input logic ack);
        exp_q.push_back({8'h80, ack});
        u_mst.write_byte(b);
    endtask
    task automatic rd(input logic [7:0] b, input logic ack);
        exp_q.push_back({1'b0, b});
        u_mst.read_byte(ack);
    endtask
    task automatic sel_read(input logic [1:0] hi, input logic [7:0] lo);
        u_mst.cond_start();
        wr(dev(hi, 1'b0), 1'b1);
        wr(lo, 1'b1);
        u_mst.cond_start();
        wr(dev(2'b00, 1'b1), 1'b1);
    endtask
    task automatic check_busy(input logic e);
        comparisons++;
        if (busy !== e)
            fail("write busy", {8'h00, e}, {8'h00, busy});
    endtask
    initial
    begin
        d0 = 8'($random(seed));
        d1 = 8'($random(seed));
        repeat (12) @(posedge clk);
        cs_pin <= 1'($random(seed));
        reset_n <= 1'b1;
        repeat (4) @(posedge clk);
        u_mst.cond_start();
        wr(dev(2'b00, 1'b1), 1'b1);
        rd(EEWP_ERASED, 1'b0);
        u_mst.cond_stop();
        $display("test current read done");
        u_mst.cond_start();
        wr(dev(2'b11, 1'b0), 1'b1);
        wr(8'hFF, 1'b1);
        wr(d0, 1'b1);
        wr(d1, 1'b1);
        check_busy(1'b0);
        u_mst.cond_stop();
        u_mst.cond_start();
        wr(dev(2'b11, 1'b0), 1'b0);
        u_mst.cond_stop();
        check_busy(1'b1);
        for (int i = 0; i < 400 && busy !== 1'b0; i++)
            @(posedge clk);
        check_busy(1'b0);
        if (busy !== 1'b0)
            complete_run();
        $display("test page write done");
        sel_read(2'b11, 8'hFF);
        rd(d0, 1'b1);
        rd(EEWP_ERASED, 1'b1);
        rd(EEWP_ERASED, 1'b0);
        u_mst.cond_stop();
        repeat (4) @(posedge clk);
        check_busy(1'b0);
        $display("test sequential read done");
        wp <= 1'b1;
        u_mst.cond_start();
        wr(dev(2'b11, 1'b0), 1'b1);
        wr(8'hF0, 1'b1);
        wr(~d1, 1'b0);
        wr(d1, 1'b0);
        u_mst.cond_stop();
        repeat (4) @(posedge clk);
        check_busy(1'b0);
        wp <= 1'b0;
        sel_read(2'b11, 8'hF0);
        rd(d1, 1'b1);
        rd(EEWP_ERASED, 1'b0);
        u_mst.cond_stop();
        $display("test write protect done");
        u_mst.cond_start();
        wr({EEWP_DEV_PREFIX, ~cs_pin, 3'b001}, 1'b0);
        u_mst.cond_stop();
        $display("test address mismatch done");
        repeat (4) @(posedge clk);
        complete_run();
    end
endmodule

`default_nettype wire
